//--- bridge_control_config_regs.v
// Bridge control, interrupt pin and capability identifier registers on Avalon-MM
// What this block does
// - Interrupt pin byte resets to zero; no legacy interrupts by default.
// - Bit 0 set reports secondary poisoned packets as parity errors; clear ignores them.
// - Bit 1 set forwards secondary error messages to primary; clear blocks them.
// - Forwarded errors leave only when command or device control reporting is enabled.
// - Bit 2, ISA addressing enable, is read-only zero.
// - Early revisions: bit 3 writable, forwards legacy display accesses primary to secondary.
// - Later revision: bit 3 reads zero and nothing is forwarded.
// - Setting bit 6 drives a hot reset onto the secondary interface.
// - Capability header low byte is read-only 0x10.
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
`include "bridge_ctrl_regs.vh"
module bridge_control_config_regs #(
	parameter LATE_REVISION = 0, // 1 selects the later silicon revision
	parameter ADDR_WIDTH = 10 // Byte address width of the slave
) (
	input wire clk, // Core clock, 40 MHz
	input wire rst, // Synchronous reset, active high
	input wire ce, // Clock enable, freezes all state when low
	input wire [ADDR_WIDTH-1:0] address, // Byte address, word aligned
	input wire read, // Read request
	input wire write, // Write request
	input wire [31:0] writedata, // Write data
	input wire [3:0] byteenable, // Byte lane enables
	output reg [31:0] readdata, // Read data
	output wire waitrequest, // Slave not ready
	input wire cmdErrReportEnable, // Error reporting enable from command register
	input wire devCtlErrReportEnable, // Error reporting enable from device control
	input wire secPoisonValid, // Poisoned packet seen on secondary side
	input wire secErrValid, // Error message on secondary side
	input wire [1:0] secErrType, // Secondary error message type
	input wire priDisplayValid, // Primary legacy display access arrives
	output wire parityErrReport, // Pulse: poisoned packet reported
	output wire priErrValid, // Pulse: error message on primary side
	output wire [1:0] priErrType, // Forwarded error message type
	output reg displayForward, // Pulse: display access forwarded
	output reg displayBlock, // Pulse: display access blocked
	output wire secondaryHotReset, // Level: hot reset on secondary interface
	output wire [7:0] legacyIntPinSelect // Current interrupt pin byte
);

	// =========================================================
	// Word-index decode, shared by read and write paths
	function [1:0] decodeSel;
		input [ADDR_WIDTH-1:0] addr;
		begin
			if (addr[1:0] != 2'h0) begin
				decodeSel = 2'h0;
			end else if (addr[ADDR_WIDTH-1:2] == `IDX_INT_PIN) begin
				decodeSel = 2'h1;
			end else if (addr[ADDR_WIDTH-1:2] == `IDX_BRIDGE_CTRL) begin
				decodeSel = 2'h2;
			end else if (addr[ADDR_WIDTH-1:2] == `IDX_LINK_CAP_HDR) begin
				decodeSel = 2'h3;
			end else begin
				decodeSel = 2'h0;
			end
		end
	endfunction

	localparam [1:0] SEL_NONE = 2'h0;
	localparam [1:0] SEL_INT_PIN = 2'h1;
	localparam [1:0] SEL_BRIDGE = 2'h2;
	localparam [1:0] SEL_CAP = 2'h3;

	wire isStatus = (address[1:0] == 2'h0) && (address[ADDR_WIDTH-1:2] == `IDX_SEC_STATUS);

	// =========================================================
	// Bus handshake: answer one cycle after the request is seen
	reg ackFf;
	wire request = read | write;
	wire nxt_ack = request & ~ackFf;
	wire accept = request & ackFf;

	assign waitrequest = request & ~ackFf;

	always @(posedge clk) begin
		if (rst) begin
			ackFf <= 1'b0;
		end else if (ce) begin
			ackFf <= nxt_ack;
		end
	end

	wire [1:0] sel = decodeSel(address);
	wire doWrite = write & accept & ce;

	// =========================================================
	// Interrupt pin byte
	reg [7:0] intPin_ff;

	always @(posedge clk) begin
		if (rst) begin
			intPin_ff <= `INT_PIN_RESET;
		end else if (doWrite && sel == SEL_INT_PIN && byteenable[0]) begin
			intPin_ff <= writedata[7:0];
		end
	end

	assign legacyIntPinSelect = intPin_ff;

	// =========================================================
	// Bridge control writable bits
	reg poisonResp_ff;
	reg errForward_ff;
	reg displayFwd_ff;
	reg hotReset_ff;
	wire displayWritable = (LATE_REVISION == 0);

	always @(posedge clk) begin
		if (rst) begin
			poisonResp_ff <= 1'b0;
			errForward_ff <= 1'b0;
			displayFwd_ff <= 1'b0;
			hotReset_ff <= 1'b0;
		end else if (doWrite && sel == SEL_BRIDGE && byteenable[0]) begin
			poisonResp_ff <= writedata[`BC_POISON_RESP];
			errForward_ff <= writedata[`BC_ERR_FWD];
			displayFwd_ff <= writedata[`BC_DISPLAY_FWD] & displayWritable;
			hotReset_ff <= writedata[`BC_SEC_HOT_RST];
		end
	end

	assign secondaryHotReset = hotReset_ff;

	wire [15:0] bridgeCtrlView;
	assign bridgeCtrlView[`BC_POISON_RESP] = poisonResp_ff;
	assign bridgeCtrlView[`BC_ERR_FWD] = errForward_ff;
	assign bridgeCtrlView[`BC_ISA_ADDR] = 1'b0;
	assign bridgeCtrlView[`BC_DISPLAY_FWD] = displayFwd_ff & displayWritable;
	assign bridgeCtrlView[5:4] = 2'h0;
	assign bridgeCtrlView[`BC_SEC_HOT_RST] = hotReset_ff;
	assign bridgeCtrlView[15:7] = 9'h000;

	// =========================================================
	// Legacy display access steering
	always @(posedge clk) begin
		if (rst) begin
			displayForward <= 1'b0;
			displayBlock <= 1'b0;
		end else if (ce) begin
			displayForward <= priDisplayValid & displayFwd_ff & displayWritable;
			displayBlock <= priDisplayValid & ~(displayFwd_ff & displayWritable);
		end
	end

	// =========================================================
	// Secondary error path
	wire errBlockedPulse;

	sec_error_path errPath (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.poisonRespEnable(poisonResp_ff),
		.errForwardEnable(errForward_ff),
		.cmdErrReportEnable(cmdErrReportEnable),
		.devCtlErrReportEnable(devCtlErrReportEnable),
		.secPoisonValid(secPoisonValid),
		.secErrValid(secErrValid),
		.secErrType(secErrType),
		.parityErrReport(parityErrReport),
		.priErrValid(priErrValid),
		.priErrType(priErrType),
		.errBlocked(errBlockedPulse)
	);

	// =========================================================
	// Sticky secondary status, write one to clear, set wins
	reg [2:0] status_ff;
	wire [2:0] statusSet = {errBlockedPulse, priErrValid, parityErrReport};
	wire [2:0] statusClr;
	reg [2:0] nxt_status;

	assign statusClr = (doWrite && isStatus && byteenable[0]) ? writedata[2:0] : 3'h0;

	always @* begin
		nxt_status = (status_ff & ~statusClr) | statusSet;
	end

	always @(posedge clk) begin
		if (rst) begin
			status_ff <= 3'h0;
		end else if (ce) begin
			status_ff <= nxt_status;
		end
	end

	// =========================================================
	// Read data, registered at the end of the request cycle, while waitrequest is still high
	reg [31:0] nxt_readdata;

	always @* begin
		nxt_readdata = 32'h00000000;
		if (isStatus) begin
			nxt_readdata = {29'h00000000, status_ff};
		end else begin
			case (sel)
				SEL_INT_PIN: begin
					nxt_readdata = {24'h000000, intPin_ff};
				end
				SEL_BRIDGE: begin
					nxt_readdata = {16'h0000, bridgeCtrlView};
				end
				SEL_CAP: begin
					nxt_readdata = {24'h000000, `CAP_IDENT_VALUE};
				end
				default: begin
					nxt_readdata = 32'h00000000;
				end
			endcase
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			readdata <= 32'h00000000;
		end else if (ce && read && nxt_ack) begin
			readdata <= nxt_readdata;
		end
	end

endmodule // bridge_control_config_regs

//--- bridge_control_config_regs_props.sv
// Port assertions for the bridge control bank
`timescale 1ns/1ps
module bridge_control_config_regs_props #(
	parameter LATE_REVISION = 0,
	parameter ADDR_WIDTH = 10
) (
	input wire clk,
	input wire rst,
	input wire ce,
	input wire [ADDR_WIDTH-1:0] address,
	input wire read,
	input wire write,
	input wire [31:0] writedata,
	input wire [3:0] byteenable,
	input wire [31:0] readdata,
	input wire waitrequest,
	input wire cmdErrReportEnable,
	input wire devCtlErrReportEnable,
	input wire secPoisonValid,
	input wire secErrValid,
	input wire [1:0] secErrType,
	input wire priDisplayValid,
	input wire parityErrReport,
	input wire priErrValid,
	input wire [1:0] priErrType,
	input wire displayForward,
	input wire displayBlock,
	input wire secondaryHotReset,
	input wire [7:0] legacyIntPinSelect
);
	localparam [ADDR_WIDTH-1:0] BC_ADDR = 10'h0F8;
	localparam [ADDR_WIDTH-1:0] CAP_ADDR = 10'h100;
	wire done;
	wire bcWrite;
	assign done = (read || write) && !waitrequest && ce;
	assign bcWrite = done && write && address == BC_ADDR && byteenable[0];
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	a_pin_reset: assert property ($past(rst) |-> legacyIntPinSelect == 8'h00)
		else $error("interrupt pin not zero after reset");
	a_poison_cause: assert property (parityErrReport |-> $past(secPoisonValid && ce))
		else $error("parity report without poisoned packet");
	a_err_type: assert property (priErrValid |-> $past(secErrValid) && priErrType == $past(secErrType))
		else $error("forwarded error without matching message");
	a_err_enable: assert property (priErrValid |-> $past(cmdErrReportEnable || devCtlErrReportEnable))
		else $error("error forwarded with reporting off");
	a_ctrl_reserved: assert property (done && read && address == BC_ADDR |-> readdata[2] == 1'b0 && readdata[15:7] == 9'h000)
		else $error("read-only control bits not zero");
	a_display_one: assert property (priDisplayValid && ce |=> displayForward != displayBlock)
		else $error("display access not answered once");
	a_display_cause: assert property ((displayForward || displayBlock) |-> $past(priDisplayValid) && (LATE_REVISION == 0 || displayBlock))
		else $error("display pulse without cause");
	a_hot_level: assert property (bcWrite |=> secondaryHotReset == $past(writedata[6]))
		else $error("hot reset not following control bit");
	a_hot_change: assert property ($changed(secondaryHotReset) |-> $past(rst) || $past(bcWrite))
		else $error("hot reset changed without write");
	a_cap_value: assert property (done && read && address == CAP_ADDR |-> readdata == 32'h00000010)
		else $error("capability header wrong");
	a_answer_soon: assert property ((read || write) && ce |-> ##[0:1] !waitrequest)
		else $error("bus answer late");
endmodule // bridge_control_config_regs_props
bind bridge_control_config_regs bridge_control_config_regs_props #(
	.LATE_REVISION(LATE_REVISION), .ADDR_WIDTH(ADDR_WIDTH)) props_i (
	.clk(clk), .rst(rst), .ce(ce), .address(address), .read(read), .write(write),
	.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
	.waitrequest(waitrequest), .cmdErrReportEnable(cmdErrReportEnable),
	.devCtlErrReportEnable(devCtlErrReportEnable), .secPoisonValid(secPoisonValid),
	.secErrValid(secErrValid), .secErrType(secErrType), .priDisplayValid(priDisplayValid),
	.parityErrReport(parityErrReport), .priErrValid(priErrValid), .priErrType(priErrType),
	.displayForward(displayForward), .displayBlock(displayBlock),
	.secondaryHotReset(secondaryHotReset), .legacyIntPinSelect(legacyIntPinSelect));

//--- bridge_ctrl_regs.vh
// Register offsets, field positions, reset values and timing for the bridge control bank
`ifndef BRIDGE_CTRL_REGS_VH
`define BRIDGE_CTRL_REGS_VH

// =========================================================
// Register indices (byte address is index times four)
`define IDX_INT_PIN 8'h3D
`define IDX_BRIDGE_CTRL 8'h3E
`define IDX_LINK_CAP_HDR 8'h40
`define IDX_SEC_STATUS 8'h80

// =========================================================
// Bridge control fields
`define BC_POISON_RESP 0
`define BC_ERR_FWD 1
`define BC_ISA_ADDR 2
`define BC_DISPLAY_FWD 3
`define BC_SEC_HOT_RST 6

// =========================================================
// Secondary status fields (write one to clear)
`define ST_POISON_SEEN 0
`define ST_ERR_FORWARDED 1
`define ST_ERR_BLOCKED 2

// =========================================================
// Reset and fixed values
`define INT_PIN_RESET 8'h00
`define BRIDGE_CTRL_RESET 16'h0000
`define CAP_IDENT_VALUE 8'h10
`define INT_PIN_ADVISED_MAX 8'h04

// =========================================================
// Bus timing: cycles from request to answer
`define BUS_ANSWER_CYCLES 1

`endif

//--- sec_error_path.v
// Secondary-to-primary error and poisoned packet path of the bridge
`timescale 1ns/1ps
module sec_error_path (
	input wire clk, // Core clock
	input wire rst, // Synchronous reset, active high
	input wire ce, // Clock enable
	input wire poisonRespEnable, // Bridge control bit 0
	input wire errForwardEnable, // Bridge control bit 1
	input wire cmdErrReportEnable, // Error reporting enable from command register
	input wire devCtlErrReportEnable, // Error reporting enable from device control
	input wire secPoisonValid, // Poisoned packet seen on secondary side
	input wire secErrValid, // Error message on secondary side
	input wire [1:0] secErrType, // 0 correctable, 1 nonfatal, 2 fatal
	output reg parityErrReport, // Pulse: poisoned packet reported as parity error
	output reg priErrValid, // Pulse: error message sent on primary side
	output reg [1:0] priErrType, // Type of forwarded error message
	output reg errBlocked // Pulse: error message dropped
);

	// =========================================================
	// Forwarding decision
	wire errTypeLegal = (secErrType != 2'h3);
	wire reportAllowed = cmdErrReportEnable | devCtlErrReportEnable;
	wire forwardNow = secErrValid & errTypeLegal & errForwardEnable & reportAllowed;

	always @(posedge clk) begin
		if (rst) begin
			parityErrReport <= 1'b0;
			priErrValid <= 1'b0;
			priErrType <= 2'h0;
			errBlocked <= 1'b0;
		end else if (ce) begin
			parityErrReport <= secPoisonValid & poisonRespEnable;
			priErrValid <= forwardNow;
			if (forwardNow) begin
				priErrType <= secErrType;
			end
			errBlocked <= secErrValid & errTypeLegal & ~forwardNow;
		end
	end

endmodule // sec_error_path

//--- sec_link_model.sv
// Far-side event source: secondary link and primary display traffic
`timescale 1ns/1ps
module sec_link_model (
	input wire clk, // Core clock
	output logic secPoisonValid, // Poisoned packet
	output logic secErrValid, // Error message
	output logic [1:0] secErrType, // Message type
	output logic priDisplayValid // Display access
);
	initial begin
		secPoisonValid = 1'b0;
		secErrValid = 1'b0;
		secErrType = 2'h0;
		priDisplayValid = 1'b0;
	end
	// One-cycle pulse; type line inverted once released
	task send(input logic p, input logic e, input logic [1:0] t, input logic d);
		@(posedge clk);
		secPoisonValid <= p;
		secErrValid <= e;
		secErrType <= t;
		priDisplayValid <= d;
		@(posedge clk);
		secPoisonValid <= 1'b0;
		secErrValid <= 1'b0;
		secErrType <= ~t;
		priDisplayValid <= 1'b0;
	endtask
endmodule // sec_link_model

//--- tb.sv
// Self-checking bench for the bridge control bank
`timescale 1ns/1ps
module tb;
	logic clk, rst, read, write, cmdEn, devEn, sP, sE, pD, pE, par, dF, dB, hot, wr;
	logic ce, dF2, dB2;
	logic [31:0] rd2, rdv2;
	int stM;
	logic [1:0] sT, pT;
	logic [9:0] addr;
	logic [31:0] wd, rd, rdv;
	logic [3:0] be;
	logic [7:0] pin;
	int err_count, checks, bcM, pinM, i, seed;
	bridge_control_config_regs #(.LATE_REVISION(1)) bridge_control_config_regs_late_i (
		.clk(clk), .rst(rst), .ce(ce), .address(addr), .read(read), .write(write),
		.writedata(wd), .byteenable(be), .readdata(rd2), .waitrequest(),
		.cmdErrReportEnable(cmdEn), .devCtlErrReportEnable(devEn), .secPoisonValid(sP),
		.secErrValid(sE), .secErrType(sT), .priDisplayValid(pD), .parityErrReport(),
		.priErrValid(), .priErrType(), .displayForward(dF2), .displayBlock(dB2),
		.secondaryHotReset(), .legacyIntPinSelect());
	bridge_control_config_regs bridge_control_config_regs_i (.clk(clk), .rst(rst), .ce(ce),
		.address(addr), .read(read), .write(write), .writedata(wd), .byteenable(be),
		.readdata(rd), .waitrequest(wr), .cmdErrReportEnable(cmdEn),
		.devCtlErrReportEnable(devEn), .secPoisonValid(sP), .secErrValid(sE), .secErrType(sT),
		.priDisplayValid(pD), .parityErrReport(par), .priErrValid(pE), .priErrType(pT),
		.displayForward(dF), .displayBlock(dB), .secondaryHotReset(hot),
		.legacyIntPinSelect(pin));
	sec_link_model sec_link_model_i (.clk(clk), .secPoisonValid(sP), .secErrValid(sE),
		.secErrType(sT), .priDisplayValid(pD));
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Avalon access, model updated at the accepting edge
	task bus(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [3:0] b);
		int n;
		@(posedge clk);
		read <= !w;
		write <= w;
		addr <= a;
		wd <= d;
		be <= b;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wr !== 1'b0 && n < 50);
		if (wr !== 1'b0) begin
			err_count++;
			finish_test;
		end
		rdv = rd;
		rdv2 = rd2;
		read <= 1'b0;
		write <= 1'b0;
		if (w && b[0] && a == 10'h0F4)
			pinM = d[7:0];
		if (w && b[0] && a == 10'h0F8)
			bcM = d & 32'h0000004B;
	endtask
	task rdchk(input logic [9:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, 4'hF);
		chk("readdata", e, rdv);
	endtask
	task ev;
		logic p, e, d, c, v;
		logic [1:0] t;
		logic ee;
		{p, e, d, c, v, t} = 7'($urandom);
		ee = e & bcM[1] & (c | v) & (t != 2'h3);
		stM = stM | {e & (t != 2'h3) & !ee, ee, p & bcM[0]};
		cmdEn <= c;
		devEn <= v;
		sec_link_model_i.send(p, e, t, d);
		@(posedge clk);
		chk("events", {p & bcM[0], ee, d & bcM[3], d & !bcM[3]}, {par, pE, dF, dB});
		if (ee)
			chk("errType", t, pT);
		chk("hotReset", bcM[6], hot);
		chk("lateDisplay", {1'b0, d}, {dF2, dB2});
	endtask
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		{rst, read, write, cmdEn, devEn, addr, wd, be} = {3'b100, 2'b00, 46'h0};
		{err_count, checks, bcM, pinM, stM} = 0;
		ce = 1'b1;
		seed = $urandom(32'h9A9F);
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rdchk(10'h0F4, 32'h0);
		rdchk(10'h0F8, 32'h0);
		rdchk(10'h100, 32'h00000010);
		rdchk(10'h3FC, 32'h0);
		rdchk(10'h0F9, 32'h0);
		$display("test reset done");
		bus(1'b1, 10'h0F8, 32'hFFFFFFFF, 4'hF);
		rdchk(10'h0F8, 32'h0000004B);
		chk("lateCtrl", 32'h00000043, rdv2);
		bus(1'b1, 10'h0F8, 32'h0, 4'hE);
		rdchk(10'h0F8, 32'h0000004B);
		bus(1'b1, 10'h100, 32'h0, 4'hF);
		rdchk(10'h100, 32'h00000010);
		for (i = 0; i < 5; i++) begin
			bus(1'b1, 10'h0F4, i, 4'hF);
			rdchk(10'h0F4, pinM);
			chk("intPin", pinM, pin);
		end
		$display("test registers done");
		for (i = 0; i < 60; i++) begin
			bus(1'b1, 10'h0F8, $urandom, 4'hF);
			ev;
			ev;
		end
		ce <= 1'b0;
		sec_link_model_i.send(1'b1, 1'b1, 2'h0, 1'b1);
		@(posedge clk);
		chk("frozen", 4'h0, {par, pE, dF, dB});
		ce <= 1'b1;
		rdchk(10'h200, stM);
		bus(1'b1, 10'h200, 32'h00000007, 4'hF);
		rdchk(10'h200, 32'h0);
		$display("test events done");
		finish_test;
	end
endmodule // tb
